// ==== hdl/timer_pulse_gen.sv ====
// 16-bit up-counting timer with one-shot and programmable pulse output
// assumes an apb master on pclk and a trigger pin synchronous to pclk
//
// Overview of operation
// RULE1 - software trigger clears and starts the counter
// RULE2 - one-shot: active at width, inactive at period
// RULE3 - counter keeps running after pulse; mode 00 stops
// RULE4 - software never retriggers during a running pulse
// RULE5 - period match raises period-match interrupt
// RULE6 - software keeps 0 < width < period
// RULE7 - nonzero mode bits start counting; zero stops
// RULE8 - valid pin edge clears and restarts one-shot
// RULE9 - edge select bits pick rise, fall, both
// RULE10 - width above period swaps activate/deactivate matches
// RULE11 - pin edges ignored while pulse is running
// RULE12 - output control: initial level, inversion, one-shot enable
// RULE13 - pulse generator clears counter on period match
// RULE14 - pulse generator drives continuous rectangular wave
// RULE15 - cycle period+1 counts, width width+1 counts
// RULE16 - matches and outputs act on count-clock ticks
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/100ps
module timer_pulse_gen (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins
  input wire logic trigger_input_pin,
  output logic timer_output_pin,
  // interrupt
  output logic timer_irq
);
  function automatic logic at(input logic [7:0] a, input logic [7:0] off);
    at = (a == off);
  endfunction

  count_if cif ();

  // registers
  logic [7:0] mode_q;
  logic [7:0] capt_q;
  logic [7:0] outc_q;
  logic [7:0] pres_q;
  logic [15:0] per_q;
  logic [15:0] wid_q;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic [1:0] sta_q;
  logic [1:0] sta_d;
  logic [1:0] msk_q;
  logic busy_q;
  logic busy_d;
  logic out_q;
  logic out_d;
  logic pin_q;
  logic irq_q;
  logic [31:0] prdata_q;
  logic [31:0] rd_mux;
  logic pready_q;
  logic pslverr_q;

  // bus decode
  logic setup;
  logic acc;
  logic wr_en;
  logic rd_en;
  logic mapped;
  assign setup = psel && !penable;
  assign acc = psel && penable && pready_q;
  assign wr_en = acc && pwrite;
  assign rd_en = acc && !pwrite;
  assign mapped = at(paddr, tmr_pkg::OFF_MODE) || at(paddr, tmr_pkg::OFF_CAPT) ||
                  at(paddr, tmr_pkg::OFF_OUTC) || at(paddr, tmr_pkg::OFF_PRES) ||
                  at(paddr, tmr_pkg::OFF_PER) || at(paddr, tmr_pkg::OFF_WID) ||
                  at(paddr, tmr_pkg::OFF_CNT) || at(paddr, tmr_pkg::OFF_STAT) ||
                  at(paddr, tmr_pkg::OFF_MASK);
  assign rd_mux = at(paddr, tmr_pkg::OFF_MODE) ? {24'h000000, mode_q} :
                  at(paddr, tmr_pkg::OFF_CAPT) ? {24'h000000, capt_q} :
                  at(paddr, tmr_pkg::OFF_OUTC) ? {24'h000000, outc_q} :
                  at(paddr, tmr_pkg::OFF_PRES) ? {24'h000000, pres_q} :
                  at(paddr, tmr_pkg::OFF_PER) ? {16'h0000, per_q} :
                  at(paddr, tmr_pkg::OFF_WID) ? {16'h0000, wid_q} :
                  at(paddr, tmr_pkg::OFF_CNT) ? {16'h0000, cnt_q} :
                  at(paddr, tmr_pkg::OFF_STAT) ? {30'h0, sta_q} :
                  at(paddr, tmr_pkg::OFF_MASK) ? {30'h0, msk_q} : 32'h00000000;

  // mode decode
  logic [1:0] op_mode;
  logic run;
  logic ppg;
  logic os_en;
  logic init_lvl;
  logic act_lvl;
  logic os_swap;
  assign op_mode = mode_q[tmr_pkg::MODE_LSB +: 2];
  assign run = (op_mode != tmr_pkg::MODE_STOP); // RULE7
  assign ppg = (op_mode == tmr_pkg::MODE_PPG);
  assign os_en = outc_q[tmr_pkg::OC_OS_EN]; // RULE12
  assign init_lvl = outc_q[tmr_pkg::OC_INIT]; // RULE12
  assign act_lvl = !init_lvl;
  assign os_swap = (wid_q > per_q); // RULE10
  assign cif.div_sel = pres_q[tmr_pkg::PRES_DIV_LSB +: 2];
  assign cif.edge_sel = pres_q[tmr_pkg::PRES_EDGE_LSB +: 2]; // RULE9

  // triggers and count step
  logic sw_trig;
  logic step;
  logic ext_ok;
  logic ppg_wrap;
  logic [15:0] cnt_next;
  logic per_hit;
  logic wid_hit;
  logic set_hit;
  logic end_hit;
  assign sw_trig = wr_en && at(paddr, tmr_pkg::OFF_OUTC) && pwdata[tmr_pkg::OC_TRIG] &&
                   os_en; // RULE1
  assign step = cif.tick && run; // RULE16
  assign ext_ok = step && cif.trig_edge && os_en && outc_q[tmr_pkg::OC_EXT_EN] &&
                  !busy_q; // RULE8 RULE11
  assign ppg_wrap = ppg && (cnt_q == per_q); // RULE13 RULE15
  assign cnt_next = (ext_ok || ppg_wrap) ? 16'h0000 : 16'(cnt_q + 16'h0001);
  assign per_hit = step && (cnt_next == per_q); // RULE16
  assign wid_hit = step && (cnt_next == wid_q); // RULE16
  assign set_hit = os_swap ? per_hit : wid_hit; // RULE2 RULE10
  assign end_hit = os_swap ? wid_hit : per_hit; // RULE2 RULE10
  assign cnt_d = (!run || sw_trig) ? 16'h0000 : step ? cnt_next : cnt_q; // RULE1 RULE3 RULE7

  // one-shot state
  assign busy_d = (!run || !os_en) ? 1'b0 :
                  (sw_trig || ext_ok) ? 1'b1 :
                  end_hit ? 1'b0 : busy_q;

  // output flip-flop
  logic os_out;
  logic ppg_out;
  logic free_out;
  assign os_out = (!busy_q || end_hit) ? init_lvl : set_hit ? act_lvl : out_q; // RULE2
  assign ppg_out = per_hit ? act_lvl : wid_hit ? init_lvl : out_q; // RULE14 RULE15
  assign free_out = out_q ^ (per_hit && outc_q[tmr_pkg::OC_INV_P]) ^
                    (wid_hit && outc_q[tmr_pkg::OC_INV_W]); // RULE12
  assign out_d = (!run || sw_trig) ? init_lvl : os_en ? os_out : ppg ? ppg_out : free_out;

  // status: set wins over read clear
  logic [1:0] sta_set;
  logic sta_clr;
  assign sta_set = {wid_hit, per_hit}; // RULE5
  assign sta_clr = rd_en && at(paddr, tmr_pkg::OFF_STAT);
  assign sta_d = (sta_q & ~{2{sta_clr}}) | sta_set;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= tmr_pkg::RST_CTRL8;
      capt_q <= tmr_pkg::RST_CTRL8;
      outc_q <= tmr_pkg::RST_CTRL8;
      pres_q <= tmr_pkg::RST_CTRL8;
      per_q <= tmr_pkg::RST_CMP;
      wid_q <= tmr_pkg::RST_CMP;
      msk_q <= tmr_pkg::RST_ST;
    end else if (wr_en) begin
      if (at(paddr, tmr_pkg::OFF_MODE)) begin
        mode_q <= pwdata[7:0];
      end
      if (at(paddr, tmr_pkg::OFF_CAPT)) begin
        capt_q <= pwdata[7:0];
      end
      if (at(paddr, tmr_pkg::OFF_OUTC)) begin
        outc_q <= pwdata[7:0] & tmr_pkg::OC_STORE_MASK;
      end
      if (at(paddr, tmr_pkg::OFF_PRES)) begin
        pres_q <= pwdata[7:0];
      end
      if (at(paddr, tmr_pkg::OFF_PER)) begin
        per_q <= pwdata[15:0];
      end
      if (at(paddr, tmr_pkg::OFF_WID)) begin
        wid_q <= pwdata[15:0];
      end
      if (at(paddr, tmr_pkg::OFF_MASK)) begin
        msk_q <= pwdata[1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 16'h0000;
      busy_q <= 1'b0;
      out_q <= 1'b0;
      pin_q <= 1'b0;
      sta_q <= tmr_pkg::RST_ST;
      irq_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      busy_q <= busy_d;
      out_q <= out_d;
      pin_q <= outc_q[tmr_pkg::OC_OE] ? out_d : init_lvl;
      sta_q <= sta_d;
      irq_q <= |(sta_d & msk_q);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= setup;
      pslverr_q <= setup && !mapped;
      if (setup) begin
        prdata_q <= rd_mux;
      end
    end
  end

  count_prescale u_prescale (
    .pclk(pclk),
    .presetn(presetn),
    .trig_pin(trigger_input_pin),
    .cif(cif)
  );

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign timer_output_pin = pin_q;
  assign timer_irq = irq_q;

  a_sw_trig_clear: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
    sw_trig && run |=> cnt_q == 16'h0000 && busy_q)
    else $error("software trigger did not restart counter");
  a_os_activate: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
    os_en && busy_q && !os_swap && wid_hit && !per_hit && !sw_trig |=> out_q == act_lvl)
    else $error("one-shot output not activated on width match");
  a_os_finish: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
    os_en && busy_q && end_hit && !sw_trig |=> out_q == init_lvl && !busy_q)
    else $error("one-shot output not ended on closing match");
  a_keep_run: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
    $fell(busy_q) && run && !ppg && !$past(sw_trig) |-> cnt_q == $past(cnt_next))
    else $error("counter stopped after one-shot pulse");
  a_period_irq: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
    per_hit ##1 !sta_clr |-> sta_q[tmr_pkg::ST_PER] ##1
    (irq_q || !$past(msk_q[tmr_pkg::ST_PER])))
    else $error("period match did not raise interrupt");
  a_stop_clear: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
    !run |=> cnt_q == 16'h0000)
    else $error("stopped counter not cleared");
  a_run_count: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
    step && !ext_ok && !ppg_wrap && !sw_trig |=> cnt_q == 16'($past(cnt_q) + 16'h0001))
    else $error("running counter failed to advance");
  a_ext_restart: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
    ext_ok && !sw_trig |=> cnt_q == 16'h0000 && busy_q && out_q == init_lvl)
    else $error("valid trigger edge did not restart pulse");
  a_swap_order: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
    os_en && busy_q && os_swap && per_hit && !wid_hit && !sw_trig |=> out_q == act_lvl)
    else $error("swapped order not activated on period match");
  a_ext_ignored: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
    step && cif.trig_edge && busy_q && !ppg && !sw_trig && !end_hit |=> busy_q &&
    cnt_q == 16'($past(cnt_q) + 16'h0001))
    else $error("trigger edge acted during pulse");
  a_init_level: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
    !run ##1 !run |-> out_q == $past(init_lvl))
    else $error("output not at initial level while stopped");
  a_ppg_wrap: assert property (@(posedge pclk) disable iff (!presetn) // RULE13
    step && ppg && cnt_q == per_q && !sw_trig |=> cnt_q == 16'h0000)
    else $error("pulse generator did not clear on period match");
  a_ppg_rise: assert property (@(posedge pclk) disable iff (!presetn) // RULE14
    ppg && !os_en && per_hit && !sw_trig |=> out_q == act_lvl)
    else $error("pulse generator not active at cycle start");
  a_ppg_width: assert property (@(posedge pclk) disable iff (!presetn) // RULE15
    ppg && !os_en && wid_hit && !per_hit && !sw_trig |=> out_q == init_lvl)
    else $error("pulse generator width end missed");
  a_no_tick_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE16
    run && !cif.tick && !sw_trig |=> $stable(cnt_q) && $stable(out_q))
    else $error("counter or output moved without count tick");
endmodule // timer_pulse_gen

// ==== shared/tmr_pkg.sv ====
// constants for the pulse timer: register map, field positions, resets
// assumes a 32-bit apb slave with byte addresses on an 8-bit paddr
package tmr_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W = 16;
  localparam int DIV_SEL_W = 2;
  localparam int DIV_CNT_W = 3;
  // register byte offsets
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_CAPT = 8'h04;
  localparam logic [7:0] OFF_OUTC = 8'h08;
  localparam logic [7:0] OFF_PRES = 8'h0C;
  localparam logic [7:0] OFF_PER = 8'h10;
  localparam logic [7:0] OFF_WID = 8'h14;
  localparam logic [7:0] OFF_CNT = 8'h18;
  localparam logic [7:0] OFF_STAT = 8'h1C;
  localparam logic [7:0] OFF_MASK = 8'h20;
  // timer_mode_control: op_mode_bit_a at 2, op_mode_bit_b at 3
  localparam int MODE_LSB = 2;
  localparam logic [1:0] MODE_STOP = 2'h0;
  localparam logic [1:0] MODE_PPG = 2'h3;
  // timer_output_control fields
  localparam int OC_OE = 0;
  localparam int OC_INV_P = 1;
  localparam int OC_INIT = 2;
  localparam int OC_INV_W = 3;
  localparam int OC_EXT_EN = 4;
  localparam int OC_OS_EN = 5;
  localparam int OC_TRIG = 6;
  localparam logic [7:0] OC_STORE_MASK = 8'hBF;
  // prescaler_mode_reg: divider select at 1:0, edge select at 5:4
  localparam int PRES_DIV_LSB = 0;
  localparam int PRES_EDGE_LSB = 4;
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_NONE = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // status and mask bits
  localparam int ST_PER = 0;
  localparam int ST_WID = 1;
  localparam int ST_W = 2;
  // reset values
  localparam logic [7:0] RST_CTRL8 = 8'h00;
  localparam logic [15:0] RST_CMP = 16'h0000;
  localparam logic [1:0] RST_ST = 2'h0;
endpackage

// ==== shared/count_if.sv ====
// count-clock tick and sampled trigger edge between prescaler and timer
// assumes both ends on pclk
`timescale 1ns/100ps
interface count_if;
  logic tick;
  logic trig_edge;
  logic [1:0] div_sel;
  logic [1:0] edge_sel;
  modport prov (output tick, output trig_edge, input div_sel, input edge_sel);
  modport use_ (input tick, input trig_edge, output div_sel, output edge_sel);
endinterface

// ==== hdl/count_prescale.sv ====
// prescaler making the count-clock enable, and trigger edge detection
// assumes the trigger pin is synchronous to pclk
`timescale 1ns/100ps
module count_prescale (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // trigger pin
  input wire logic trig_pin,
  // to timer
  count_if.prov cif
);
  function automatic logic [2:0] div_mask(input logic [1:0] sel);
    div_mask = 3'((4'h1 << sel) - 4'h1);
  endfunction

  logic [2:0] div_q;
  logic [2:0] div_d;
  logic tick_q;
  logic tick_d;
  logic samp_q;
  logic edge_q;
  logic edge_d;
  logic rise;
  logic fall;

  assign tick_d = (div_q == div_mask(cif.div_sel));
  assign div_d = tick_d ? 3'h0 : 3'(div_q + 3'h1);
  assign rise = trig_pin && !samp_q;
  assign fall = !trig_pin && samp_q;
  assign edge_d = tick_d && ((cif.edge_sel == tmr_pkg::EDGE_RISE) ? rise :
                  (cif.edge_sel == tmr_pkg::EDGE_FALL) ? fall :
                  (cif.edge_sel == tmr_pkg::EDGE_BOTH) ? (rise || fall) : 1'b0); // RULE9

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 3'h0;
      tick_q <= 1'b0;
      samp_q <= 1'b0;
      edge_q <= 1'b0;
    end else begin
      div_q <= div_d;
      tick_q <= tick_d;
      edge_q <= edge_d;
      if (tick_d) begin
        samp_q <= trig_pin;
      end
    end
  end

  assign cif.tick = tick_q;
  assign cif.trig_edge = edge_q;

  a_edge_rise: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
    tick_d && cif.edge_sel == tmr_pkg::EDGE_RISE && trig_pin && !samp_q |=> edge_q && tick_q)
    else $error("rising trigger edge missed");
  a_edge_none: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
    cif.edge_sel == tmr_pkg::EDGE_NONE |=> !edge_q)
    else $error("edge flagged with no edge selected");
endmodule // count_prescale

// ==== verification/trig_load.sv ====
// trigger source and output load model for the pulse timer
// assumes pclk shared with the timer and a trigger pin synchronous to it
`timescale 1ns/100ps
module trig_load (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // burst request
  input wire logic go,
  // pins
  output logic trig_pin,
  input wire logic tout,
  // measurements
  output logic [15:0] hi_len,
  output logic [15:0] per_len,
  output logic [7:0] n_rise
);
  logic [7:0] t_q;
  logic [15:0] hi_cnt;
  logic [15:0] per_cnt;
  logic tout_q;
  // burst: high 2, low 2, high 26, then low; idle low
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t_q <= 8'h00;
      trig_pin <= 1'b0;
    end else begin
      if (go)
        t_q <= 8'h01;
      else if (t_q != 8'h00 && t_q != 8'h40)
        t_q <= t_q + 8'h01;
      trig_pin <= (t_q >= 8'h01 && t_q <= 8'h02) || (t_q >= 8'h05 && t_q <= 8'h1E);
    end
  end
  // load side: high time, rise-to-rise time, rise count
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tout_q <= 1'b0;
      hi_cnt <= 16'h0000;
      per_cnt <= 16'h0000;
      hi_len <= 16'h0000;
      per_len <= 16'h0000;
      n_rise <= 8'h00;
    end else begin
      tout_q <= tout;
      hi_cnt <= tout ? hi_cnt + 16'h0001 : 16'h0000;
      per_cnt <= (tout && !tout_q) ? 16'h0001 : per_cnt + 16'h0001;
      if (!tout && tout_q)
        hi_len <= hi_cnt;
      if (tout && !tout_q) begin
        per_len <= per_cnt;
        n_rise <= n_rise + 8'h01;
      end
    end
  end
endmodule // trig_load

// ==== verification/timer_pulse_gen_tb.sv ====
// self-checking bench for the pulse timer over apb
// assumes trig_load as far side; count clock = pclk when divider select is 0
`timescale 1ns/100ps
module timer_pulse_gen_tb;
  typedef struct {logic chk; logic [31:0] d; logic e;} note_s;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, v;
  logic trig_pin, tout, irq, go;
  logic [15:0] hi_len, per_len, per, wid;
  logic [7:0] n_rise, rise0;
  logic [7:0] exp_n [4] = '{8'h02, 8'h01, 8'h00, 8'h02};
  note_s exp_q [$];
  note_s nt;
  int n_fail = 0;
  int n_checks = 0;
  int unsigned seed_v;
  timer_pulse_gen i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trigger_input_pin(trig_pin), .timer_output_pin(tout),
    .timer_irq(irq));
  trig_load i_load (.pclk(pclk), .presetn(presetn), .go(go), .trig_pin(trig_pin),
    .tout(tout), .hi_len(hi_len), .per_len(per_len), .n_rise(n_rise));
  always #2.5 pclk = ~pclk;
  task automatic fail(input string m);
    n_fail++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp)
      fail(m);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // one apb transfer; caller is just past a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
    input logic chk, input logic [31:0] ed, input logic ee, output logic [31:0] rd);
    exp_q.push_back('{chk, ed, ee});
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // wait for the slave however long it takes; only the watchdog ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    apb(1'b1, a, d, 1'b0, 32'h0, 1'b0, x);
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] ed);
    logic [31:0] x;
    apb(1'b0, a, 32'h0, 1'b1, ed, 1'b0, x);
  endtask
  // monitor: every completed transfer takes the oldest note
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        fail("unexpected transfer");
      end else begin
        nt = exp_q.pop_front();
        n_checks++;
        if (pslverr !== nt.e || (nt.chk && prdata !== nt.d))
          fail("bus read or error response wrong");
      end
    end
  end
  initial begin
    #100000;
    fail("timeout");
    stop_test();
  end
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    go = 1'b0;
    seed_v = $urandom(4436);
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 9; i++)
      rreg(8'(4 * i), 32'h0);
    apb(1'b0, 8'h24, 32'h0, 1'b1, 32'h0, 1'b1, v);
    apb(1'b1, 8'h24, 32'hFFFF_FFFF, 1'b0, 32'h0, 1'b1, v);
    wreg(tmr_pkg::OFF_CNT, 32'h0000_1234);
    rreg(tmr_pkg::OFF_CNT, 32'h0);
    // pulse generator, random period and width, two divider settings
    for (int sel = 0; sel < 2; sel++) begin
      per = 16'(6 + $urandom % 10);
      wid = 16'(1 + $urandom % (per - 1));
      wreg(tmr_pkg::OFF_PRES, 32'(sel));
      wreg(tmr_pkg::OFF_PER, 32'(per));
      wreg(tmr_pkg::OFF_WID, 32'(wid));
      wreg(tmr_pkg::OFF_OUTC, 32'h0000_000B);
      wreg(tmr_pkg::OFF_MODE, 32'(tmr_pkg::MODE_PPG) << tmr_pkg::MODE_LSB);
      repeat ((4 * (per + 1)) << sel) @(posedge pclk);
      chk_val(32'(hi_len), 32'((wid + 1) << sel), "pulse high time");
      chk_val(32'(per_len), 32'((per + 1) << sel), "pulse period");
      wreg(tmr_pkg::OFF_MODE, 32'h0);
    end
    // interrupt: mask, level, read clear
    wreg(tmr_pkg::OFF_MASK, 32'h0);
    repeat (2) @(posedge pclk);
    chk_val(32'(irq), 32'h0, "masked interrupt seen");
    wreg(tmr_pkg::OFF_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    chk_val(32'(irq), 32'h1, "interrupt missing");
    rreg(tmr_pkg::OFF_STAT, 32'h3);
    repeat (2) @(posedge pclk);
    chk_val(32'(irq), 32'h0, "interrupt not cleared");
    rreg(tmr_pkg::OFF_STAT, 32'h0);
    // software one-shot, width below and above period
    for (int i = 0; i < 2; i++) begin
      wid = (i == 1) ? 16'h0009 : 16'h0003;
      per = (i == 1) ? 16'h0003 : 16'h0009;
      wreg(tmr_pkg::OFF_PRES, 32'h0);
      wreg(tmr_pkg::OFF_PER, 32'(per));
      wreg(tmr_pkg::OFF_WID, 32'(wid));
      wreg(tmr_pkg::OFF_OUTC, 32'h0000_002B);
      wreg(tmr_pkg::OFF_MODE, 32'h0000_0004);
      rise0 = n_rise;
      wreg(tmr_pkg::OFF_OUTC, 32'h0000_006B);
      repeat (30) @(posedge pclk);
      chk_val(32'(n_rise - rise0), 32'h1, "one-shot pulse count");
      chk_val(32'(hi_len), 32'h6, "one-shot width");
      apb(1'b0, tmr_pkg::OFF_CNT, 32'h0, 1'b0, 32'h0, 1'b0, v);
      chk_val(32'(v > 32'h0000_001E), 32'h1, "counter halted after pulse");
      wreg(tmr_pkg::OFF_MODE, 32'h0);
      rreg(tmr_pkg::OFF_CNT, 32'h0);
    end
    // pin trigger, every edge selection
    for (int e = 0; e < 4; e++) begin
      wreg(tmr_pkg::OFF_PRES, 32'(e) << tmr_pkg::PRES_EDGE_LSB);
      wreg(tmr_pkg::OFF_OUTC, 32'h0000_003B);
      wreg(tmr_pkg::OFF_MODE, 32'h0000_0004);
      rise0 = n_rise;
      go <= 1'b1;
      @(posedge pclk);
      go <= 1'b0;
      repeat (80) @(posedge pclk);
      chk_val(32'(n_rise - rise0), 32'(exp_n[e]), "pin trigger pulse count");
      wreg(tmr_pkg::OFF_MODE, 32'h0);
    end
    // stopped, output disabled, initial level high: pin shows that level
    wreg(tmr_pkg::OFF_OUTC, 32'h0000_0004);
    repeat (2) @(posedge pclk);
    chk_val(32'(tout), 32'h1, "initial output level not shown");
    stop_test();
  end
endmodule // timer_pulse_gen_tb
